// ===== rtl/pte_pkg.sv
// constants shared by the pin task and event unit
`default_nettype none
package pte_pkg;
  localparam int CH_COUNT = 8;
  localparam int PIN_COUNT = 32;
  localparam int SEL_W = 5;
  // channel mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TASK = 2'h3;
  // write action (task mode) and edge condition (event mode) share one field
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  // per-line sensing codes
  localparam logic [1:0] SENSE_OFF = 2'h0;
  localparam logic [1:0] SENSE_HIGH = 2'h2;
  localparam logic [1:0] SENSE_LOW = 2'h3;
  // reset values
  localparam logic RST_LEVEL = 1'b0;
endpackage
`default_nettype wire

// ===== rtl/pte_unit.sv
// pin task and event unit: eight pin channels plus the multi-line sense event
// Behaviour
// - eight channels, each tied to one pin by its pin-select field
// - drive-high task sets the selected pin high
// - drive-low task sets the selected pin low
// - write task sets, clears or inverts the pin per write-action field
// - event mode raises edge event on rising, falling or any change
// - a channel-owned pin ignores the port's output value and writes
// - same-cycle tasks: write task first, then drive-low, then drive-high
// - write task with action none still wins, leaving pin unchanged
// - entering task mode loads the pin level from the initial-level field
// - multi-line event on each rising edge of the sense-match signal
// - entering idle with sense-match already high gives no wake-up
// - partial clear of sticky flags with some left set makes new rising edge
// - off request while sense-match high causes immediate wake-up reset
// - sense path and multi-line event need no clock request
// - event mode forces the selected pin to input
// - task mode forces the selected pin to output with channel level
// - disabled mode returns the pin to the port's own setup
// - sensing codes: 0 off, 2 watch high, 3 watch low
// - sense-match follows lines directly or the sticky flags per mode
`timescale 1ns/1ps
`default_nettype none
module pte_unit #(
  parameter int CH = pte_pkg::CH_COUNT,
  parameter int PINS = pte_pkg::PIN_COUNT
) (
  input wire logic clk, // 100 MHz system clock
  input wire logic reset_n, // async active-low reset
  input wire logic [CH-1:0][1:0] ch_mode, // channel mode
  input wire logic [CH-1:0][pte_pkg::SEL_W-1:0] ch_pin_sel, // pin per channel
  input wire logic [CH-1:0][1:0] ch_action, // write action or edge condition
  input wire logic [CH-1:0] task_initial_level, // level loaded on task entry
  input wire logic [CH-1:0] task_write, // configurable write task pulses
  input wire logic [CH-1:0] drive_low_task, // drive-low task pulses
  input wire logic [CH-1:0] drive_high_task, // drive-high task pulses
  input wire logic [PINS-1:0] port_out, // port output values
  input wire logic [PINS-1:0] port_dir, // port direction, 1 = output
  input wire logic [PINS-1:0] pin_in, // asynchronous pad inputs
  input wire logic [PINS-1:0][1:0] line_sense, // per-line sensing field
  input wire logic held_match_mode, // 1 = sticky sense flags drive match
  input wire logic [PINS-1:0] sense_flag_clear, // write-1-to-clear pulses
  input wire logic [CH-1:0] event_flag_clear, // edge flag clear pulses
  input wire logic port_flag_clear, // multi-line flag clear pulse
  input wire logic [CH:0] irq_mask_set_reg, // mask set pulses, top = port
  input wire logic [CH:0] irq_mask_clear_reg, // mask clear pulses
  input wire logic sys_idle, // system in idle state
  input wire logic off_request, // system commanded to off state
  output logic [PINS-1:0] pad_out, // pad output level
  output logic [PINS-1:0] pad_oe, // pad output enable
  output logic [CH-1:0] edge_event, // one-cycle channel event pulses
  output logic port_event, // one-cycle multi-line event pulse
  output logic [CH-1:0] event_flag, // sticky channel flags
  output logic port_flag, // sticky multi-line flag
  output logic [PINS-1:0] sense_flag, // sticky per-line sense flags
  output logic sense_match, // registered sense-match signal
  output logic irq, // interrupt request
  output logic idle_wake, // wake pulse from idle
  output logic off_wake_reset // wake-up reset pulse out of off
);
  import pte_pkg::*;

  logic rst_meta, rst_sync;
  logic [PINS-1:0] pin_meta, pin_sync;
  logic [CH-1:0] ch_level, ch_prev, mode_task_q;
  logic [CH-1:0] ch_in, next_edge;
  logic [PINS-1:0] line_match;
  logic [CH:0] irq_mask;
  logic next_match;
  logic [PINS-1:0] next_pad_out, next_pad_oe;

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // pads are asynchronous: two flops before any use
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // per-channel input tap and edge detection
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      ch_in[c] = pin_sync[ch_pin_sel[c]];
      unique case (ch_action[c])
        EDGE_RISE: next_edge[c] = ch_in[c] & ~ch_prev[c];
        EDGE_FALL: next_edge[c] = ~ch_in[c] & ch_prev[c];
        EDGE_ANY: next_edge[c] = ch_in[c] ^ ch_prev[c];
        default: next_edge[c] = 1'b0;
      endcase
      if (ch_mode[c] != MODE_EVENT) next_edge[c] = 1'b0;
    end
  end

  // previous sample; tracks input so a mode switch gives no false edge
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ch_prev <= '0;
      edge_event <= '0;
    end else begin
      ch_prev <= ch_in;
      edge_event <= next_edge;
    end
  end

  // channel output level with task priority
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      ch_level <= {CH{RST_LEVEL}};
      mode_task_q <= '0;
    end else begin
      for (int c = 0; c < CH; c++) begin
        mode_task_q[c] <= (ch_mode[c] == MODE_TASK);
        if (ch_mode[c] != MODE_TASK) begin
          ch_level[c] <= ch_level[c];
        end else if (!mode_task_q[c]) begin
          ch_level[c] <= task_initial_level[c];
        end else if (task_write[c]) begin
          // write task wins even with action none
          unique case (ch_action[c])
            ACT_HIGH: ch_level[c] <= 1'b1;
            ACT_LOW: ch_level[c] <= 1'b0;
            ACT_TOGGLE: ch_level[c] <= ~ch_level[c];
            default: ch_level[c] <= ch_level[c];
          endcase
        end else if (drive_low_task[c]) begin
          ch_level[c] <= 1'b0;
        end else if (drive_high_task[c]) begin
          ch_level[c] <= 1'b1;
        end
      end
    end
  end

  // pad mux; a shared pin is software's fault, last channel wins here
  generate
    for (genvar p = 0; p < PINS; p++) begin : g_pad
      always_comb begin
        next_pad_out[p] = port_out[p];
        next_pad_oe[p] = port_dir[p];
        for (int c = 0; c < CH; c++) begin
          if (ch_pin_sel[c] == SEL_W'(p)) begin
            if (ch_mode[c] == MODE_TASK) begin
              next_pad_out[p] = ch_level[c];
              next_pad_oe[p] = 1'b1;
            end else if (ch_mode[c] == MODE_EVENT) begin
              next_pad_oe[p] = 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      pad_out <= '0;
      pad_oe <= '0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
    end
  end

  // per-line match; this path asks for no clock request in silicon
  generate
    for (genvar p = 0; p < PINS; p++) begin : g_line
      assign line_match[p] = (line_sense[p] == SENSE_HIGH && pin_sync[p]) ||
                             (line_sense[p] == SENSE_LOW && !pin_sync[p]);
    end
  endgenerate

  // sticky sense flags: a new match beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      sense_flag <= '0;
    end else begin
      sense_flag <= (sense_flag & ~sense_flag_clear) | line_match;
    end
  end

  // match source; a clear in held mode drops it one cycle for a fresh edge
  always_comb begin
    next_match = held_match_mode ? |((sense_flag & ~sense_flag_clear) | line_match)
                                 : |line_match;
    if (held_match_mode && |sense_flag_clear) next_match = 1'b0;
  end

  // rising edge gives the event; idle wake only on an edge, never a level
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      sense_match <= 1'b0;
      port_event <= 1'b0;
      idle_wake <= 1'b0;
      off_wake_reset <= 1'b0;
    end else begin
      sense_match <= next_match;
      port_event <= next_match & ~sense_match;
      idle_wake <= sys_idle & next_match & ~sense_match;
      off_wake_reset <= off_request & sense_match;
    end
  end

  // sticky flags; set wins over clear
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      event_flag <= '0;
      port_flag <= 1'b0;
    end else begin
      event_flag <= (event_flag & ~event_flag_clear) | next_edge;
      port_flag <= (port_flag & ~port_flag_clear) | (next_match & ~sense_match);
    end
  end

  // interrupt mask and request; order of mask and clear is up to software
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      irq_mask <= (irq_mask & ~irq_mask_clear_reg) | irq_mask_set_reg;
      irq <= |({port_flag, event_flag} & irq_mask);
    end
  end

  // checks on channel 0, the last channel's event path and the sense path
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync);

  property p_high;
    ch_mode[0] == MODE_TASK && mode_task_q[0] && drive_high_task[0] &&
      !task_write[0] && !drive_low_task[0] |=> ch_level[0];
  endproperty
  a_high: assert property (p_high) else $error("drive-high lost");

  property p_low;
    ch_mode[0] == MODE_TASK && mode_task_q[0] && drive_low_task[0] &&
      !task_write[0] |=> !ch_level[0];
  endproperty
  a_low: assert property (p_low) else $error("drive-low lost");

  property p_toggle;
    ch_mode[0] == MODE_TASK && mode_task_q[0] && task_write[0] &&
      ch_action[0] == ACT_TOGGLE |=> ch_level[0] != $past(ch_level[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle failed");

  property p_prio;
    ch_mode[0] == MODE_TASK && mode_task_q[0] && task_write[0] &&
      ch_action[0] == ACT_HIGH && drive_low_task[0] |=> ch_level[0];
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");

  property p_none;
    ch_mode[0] == MODE_TASK && mode_task_q[0] && task_write[0] &&
      ch_action[0] == ACT_NONE |=> $stable(ch_level[0]);
  endproperty
  a_none: assert property (p_none) else $error("none action changed pin");

  property p_init;
    ch_mode[0] == MODE_TASK && !mode_task_q[0] |=> ch_level[0] == $past(task_initial_level[0]);
  endproperty
  a_init: assert property (p_init) else $error("initial level not loaded");

  // the last channel is checked here: it wins a shared pin, so its pad is unambiguous
  property p_rise;
    ch_mode[CH-1] == MODE_EVENT && ch_action[CH-1] == EDGE_RISE && ch_in[CH-1] &&
      !ch_prev[CH-1] |=> edge_event[CH-1] && event_flag[CH-1];
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");

  property p_input;
    ch_mode[CH-1] == MODE_EVENT |=> !pad_oe[$past(ch_pin_sel[CH-1])];
  endproperty
  a_input: assert property (p_input) else $error("event pin driven");

  property p_port;
    !sense_match ##1 sense_match |=> $past(port_event, 1) || port_event;
  endproperty
  a_port: assert property (p_port) else $error("port event missing");

  property p_refresh;
    held_match_mode && |sense_flag_clear |=> !sense_match;
  endproperty
  a_refresh: assert property (p_refresh) else $error("no fresh edge");

  property p_off;
    off_request && sense_match |=> off_wake_reset;
  endproperty
  a_off: assert property (p_off) else $error("off wake missing");

  property p_idle;
    idle_wake |-> port_event && !$past(sense_match);
  endproperty
  a_idle: assert property (p_idle) else $error("wake from stale level");

  c_toggle: cover property (task_write[0] && ch_action[0] == ACT_TOGGLE ##1 ch_level[0]);
  c_edge: cover property (edge_event[CH-1] ##1 event_flag[CH-1]);
  c_port: cover property (port_event && held_match_mode);
endmodule
`default_nettype wire

// ===== verification/pte_pin_model.sv
// far-side pad model for the pin task and event unit
`timescale 1ns/1ps
`default_nettype none
module pte_pin_model (
  input wire logic [pte_pkg::PIN_COUNT-1:0] pad_out, // level driven by the unit
  input wire logic [pte_pkg::PIN_COUNT-1:0] pad_oe, // unit drive enable
  input wire logic [pte_pkg::PIN_COUNT-1:0] ext_level, // level forced from outside
  output logic [pte_pkg::PIN_COUNT-1:0] pin_in // level seen at the pads
);
  // a driven pad reads back its own level, an undriven one the outside world
  assign pin_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the pin task and event unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pte_pkg::*;
  logic clk = 1'b0;
  logic reset_n;
  logic [CH_COUNT-1:0][1:0] ch_mode, ch_action;
  logic [CH_COUNT-1:0][SEL_W-1:0] ch_pin_sel;
  logic [CH_COUNT-1:0] task_initial_level, task_write, drive_low_task, drive_high_task;
  logic [CH_COUNT-1:0] event_flag_clear, edge_event, event_flag;
  logic [PIN_COUNT-1:0] port_out, port_dir, pin_in, ext, sense_flag_clear;
  logic [PIN_COUNT-1:0] pad_out, pad_oe, sense_flag;
  logic [PIN_COUNT-1:0][1:0] line_sense;
  logic [CH_COUNT:0] irq_mask_set_reg, irq_mask_clear_reg;
  logic held_match_mode, port_flag_clear, sys_idle, off_request;
  logic port_event, port_flag, sense_match, irq, idle_wake, off_wake_reset;
  int failures = 0;
  int n_checks = 0;
  int ev_cnt = 0;
  int pe_cnt = 0;
  int iw_cnt = 0;
  int ow_cnt = 0;

  always #5 clk = ~clk;

  pte_unit uut (.clk(clk), .reset_n(reset_n), .ch_mode(ch_mode), .ch_pin_sel(ch_pin_sel),
    .ch_action(ch_action), .task_initial_level(task_initial_level), .task_write(task_write),
    .drive_low_task(drive_low_task), .drive_high_task(drive_high_task), .port_out(port_out),
    .port_dir(port_dir), .pin_in(pin_in), .line_sense(line_sense),
    .held_match_mode(held_match_mode), .sense_flag_clear(sense_flag_clear),
    .event_flag_clear(event_flag_clear), .port_flag_clear(port_flag_clear),
    .irq_mask_set_reg(irq_mask_set_reg), .irq_mask_clear_reg(irq_mask_clear_reg),
    .sys_idle(sys_idle), .off_request(off_request), .pad_out(pad_out), .pad_oe(pad_oe),
    .edge_event(edge_event), .port_event(port_event), .event_flag(event_flag),
    .port_flag(port_flag), .sense_flag(sense_flag), .sense_match(sense_match), .irq(irq),
    .idle_wake(idle_wake), .off_wake_reset(off_wake_reset));

  pte_pin_model pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext), .pin_in(pin_in));

  // count one-cycle pulses so that their timing spread does not matter
  always @(posedge clk) begin
    if (edge_event[7] === 1'b1) ev_cnt++;
    if (port_event === 1'b1) pe_cnt++;
    if (idle_wake === 1'b1) iw_cnt++;
    if (off_wake_reset === 1'b1) ow_cnt++;
  end

  task automatic close_out;
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one task pulse on channel 0, then the level of pad 5 once it has landed
  task automatic fire(input logic w, input logic l, input logic h, input logic exp);
    task_write[0] = w;
    drive_low_task[0] = l;
    drive_high_task[0] = h;
    cyc(1);
    task_write[0] = 1'b0;
    drive_low_task[0] = 1'b0;
    drive_high_task[0] = 1'b0;
    cyc(3);
    check(pad_out[5], exp);
  endtask

  // hang guard
  initial begin
    #200000;
    failures++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    {ch_mode, ch_action, ch_pin_sel, task_initial_level} = '0;
    {task_write, drive_low_task, drive_high_task, event_flag_clear} = '0;
    {port_out, ext, sense_flag_clear, line_sense} = '0;
    port_dir = 32'h0000_0200; // only pad 9 starts as a port output
    {irq_mask_set_reg, irq_mask_clear_reg} = '0;
    {held_match_mode, port_flag_clear, sys_idle, off_request} = '0;
    cyc(12);
    check(pad_oe, '0);
    check({event_flag, port_flag, irq}, '0);
    reset_n = 1'b1;
    cyc(4);
    // channel 0 takes pad 5 while the port itself leaves it undriven
    ch_pin_sel[0] = 5'h05;
    task_initial_level[0] = 1'b1;
    ch_action[0] = ACT_TOGGLE;
    ch_mode[0] = MODE_TASK;
    cyc(4);
    check({pad_oe[5], pad_out[5]}, 2'h3);
    fire(1'b0, 1'b1, 1'b0, 1'b0);
    fire(1'b0, 1'b0, 1'b1, 1'b1);
    fire(1'b1, 1'b0, 1'b0, 1'b0);
    fire(1'b1, 1'b0, 1'b0, 1'b1);
    ch_action[0] = ACT_LOW;
    fire(1'b1, 1'b0, 1'b1, 1'b0);
    ch_action[0] = ACT_HIGH;
    fire(1'b1, 1'b1, 1'b0, 1'b1);
    fire(1'b0, 1'b1, 1'b1, 1'b0);
    port_out = '1;
    cyc(3);
    check(pad_out[5], 1'b0);
    fire(1'b0, 1'b0, 1'b1, 1'b1);
    ch_action[0] = ACT_NONE;
    fire(1'b1, 1'b1, 1'b0, 1'b1);
    port_out = '0;
    port_dir[5] = 1'b1;
    ch_mode[0] = MODE_OFF;
    cyc(4);
    check({pad_oe[5], pad_out[5]}, 2'h2);
    // channel 7 watches pad 9 for each edge condition
    ch_pin_sel[7] = 5'h09;
    ch_mode[7] = MODE_EVENT;
    for (int e = 1; e < 4; e++) begin
      ch_action[7] = e[1:0];
      cyc(6);
      ev_cnt = 0;
      ext[9] = 1'b1;
      cyc(8);
      check(ev_cnt, (e != 2) ? 1 : 0);
      ext[9] = 1'b0;
      cyc(8);
      check(ev_cnt, (e == 3) ? 2 : 1);
    end
    check({pad_oe[9], event_flag[7]}, 2'h1);
    event_flag_clear[7] = 1'b1;
    cyc(1);
    event_flag_clear[7] = 1'b0;
    cyc(2);
    check(event_flag[7], 1'b0);
    // mask, configure sensing, clear the flag, unmask
    sys_idle = 1'b1;
    irq_mask_clear_reg[8] = 1'b1;
    cyc(1);
    irq_mask_clear_reg[8] = 1'b0;
    line_sense[3] = SENSE_HIGH;
    port_flag_clear = 1'b1;
    cyc(1);
    port_flag_clear = 1'b0;
    irq_mask_set_reg[8] = 1'b1;
    cyc(1);
    irq_mask_set_reg[8] = 1'b0;
    pe_cnt = 0;
    iw_cnt = 0;
    ext[3] = 1'b1;
    cyc(8);
    check(pe_cnt, 1);
    check({port_flag, irq, sense_match, iw_cnt != 0}, 4'hf);
    sys_idle = 1'b0;
    cyc(2);
    iw_cnt = 0;
    sys_idle = 1'b1;
    cyc(4);
    check(iw_cnt, 0);
    off_request = 1'b1;
    cyc(3);
    off_request = 1'b0;
    check(ow_cnt != 0, 1'b1);
    port_flag_clear = 1'b1;
    cyc(1);
    port_flag_clear = 1'b0;
    cyc(2);
    check({port_flag, irq}, 2'h0);
    // sticky flags: a partial clear must give a fresh match edge
    held_match_mode = 1'b1;
    line_sense[4] = SENSE_HIGH;
    ext[4] = 1'b1;
    cyc(8);
    pe_cnt = 0;
    sense_flag_clear = 32'h0000_0010;
    cyc(1);
    sense_flag_clear = '0;
    cyc(8);
    check({pe_cnt == 1, sense_flag[3]}, 2'h3);
    ext[3] = 1'b0;
    ext[4] = 1'b0;
    cyc(6);
    check(sense_match, 1'b1);
    sense_flag_clear = '1;
    cyc(1);
    sense_flag_clear = '0;
    cyc(3);
    check(sense_match, 1'b0);
    // low-level watch in direct mode follows the pad at once
    held_match_mode = 1'b0;
    line_sense[4] = SENSE_LOW;
    cyc(4);
    check(sense_match, 1'b1);
    ext[4] = 1'b1;
    cyc(5);
    check(sense_match, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
